// ===== hdl/pmat_master.sv
// Parallel master port: address, chip selects and read/write cycle sequencing
// Operation
// - Chip selects share A15/A14; lower-only unsupported
// - Both selects may assert together; software avoids
// - Select active only when its address bit set
// - Zero select bits still drive address 13:0
// - Auto-increment leaves chip-select bits unchanged
// - Multiplexed address phase forces select bits zero
// - Chip selects limit range to 16K/32K
// - No chip selects gives full 64K range
// - Data register access starts read or write
// - Busy clears one cycle before cycle end
// - Demultiplexed read 2, write 3 cycles
// - Partial mux puts address 7:0 on data
// - Partial mux read 5, write 6 cycles
// - Full 8-bit mux sends all sixteen bits
// - Full 8-bit mux read 8, write 9
// - Wait reads last 6, 10, 14 cycles
// - Wait writes last 7, 11, 15 cycles
// - Writes end with one data hold cycle
// - Eight-bit mode leaves data 15:8 undriven, except with full 16-bit mux
// - Full 16-bit mux read 5, write 6
// - Accesses while busy are ignored
module pmat_master #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] addr_mux_select,
  input wire logic mode16,
  input wire logic wait_enable,
  input wire logic auto_inc_enable,
  input wire logic cs_upper_enable,
  input wire logic cs_lower_enable,
  input wire logic addr_wr,
  input wire logic [ADDR_W-1:0] addr_wdata,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic data_rd,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic [DATA_W-1:0] bus_data_reg,
  output logic [ADDR_W-1:0] bus_address_reg,
  output logic busy,
  output logic cfg_unsupported,
  output logic [13:0] ext_address_lines,
  output logic upper_chip_select,
  output logic lower_chip_select,
  output logic [DATA_W-1:0] ext_data_lines,
  output logic ext_data_oe_low,
  output logic ext_data_oe_high,
  output logic read_strobe,
  output logic write_strobe,
  output logic addr_latch_low,
  output logic addr_latch_high
);

  // Address phase length per multiplex setting
  function automatic logic [4:0] addr_cycles(input logic [1:0] mux);
    case (mux)
      pmat_pkg::MUX_PARTIAL: addr_cycles = pmat_pkg::ADDR_CYC_PARTIAL;
      pmat_pkg::MUX_FULL8: addr_cycles = pmat_pkg::ADDR_CYC_FULL8;
      pmat_pkg::MUX_FULL16: addr_cycles = pmat_pkg::ADDR_CYC_FULL16;
      default: addr_cycles = pmat_pkg::ADDR_CYC_DEMUX;
    endcase
  endfunction

  // Strobe length, stretched when wait states are on
  function automatic logic [4:0] strobe_cycles(input logic [1:0] mux, input logic wt);
    logic [4:0] ext;
    ext = 5'h00;
    case (mux)
      pmat_pkg::MUX_PARTIAL: ext = pmat_pkg::WAIT_EXT_PARTIAL;
      pmat_pkg::MUX_FULL8: ext = pmat_pkg::WAIT_EXT_FULL8;
      pmat_pkg::MUX_FULL16: ext = pmat_pkg::WAIT_EXT_FULL16;
      default: ext = pmat_pkg::WAIT_EXT_DEMUX;
    endcase
    strobe_cycles = wt ? 5'(pmat_pkg::STROBE_CYC + ext) : pmat_pkg::STROBE_CYC;
  endfunction

  // Lower select alone is not a legal setting; it acts as an address line
  logic cs_up_en;
  logic cs_lo_en;
  assign cs_up_en = cs_upper_enable;
  assign cs_lo_en = cs_lower_enable & cs_upper_enable;

  // Cycle state
  pmat_pkg::pmat_phase_t phase;
  pmat_pkg::pmat_phase_t next_phase;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic active;
  logic next_active;
  logic is_write;
  logic [4:0] len;
  logic [4:0] apl;
  logic [4:0] strb_end;
  logic [1:0] mux;
  logic wide;
  logic [DATA_W-1:0] wdata;

  logic start;
  logic finish;
  assign start = !busy && (data_wr || data_rd);
  assign finish = active && (cnt == 5'(len - 5'h01));

  // Cycle lengths captured at start: address + setup + strobe (+ hold)
  logic [4:0] new_apl;
  logic [4:0] new_strb;
  logic [4:0] new_len;
  always_comb
  begin
    new_apl = addr_cycles(addr_mux_select);
    new_strb = 5'(new_apl + pmat_pkg::SETUP_CYC + strobe_cycles(addr_mux_select, wait_enable));
    new_len = data_wr ? 5'(new_strb + pmat_pkg::HOLD_CYC) : new_strb;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      is_write <= 1'b0;
      len <= 5'h00;
      apl <= 5'h00;
      strb_end <= 5'h00;
      mux <= pmat_pkg::MUX_DEMUX;
      wide <= 1'b0;
      wdata <= pmat_pkg::DATA_RESET;
    end
    else if (start)
    begin
      is_write <= data_wr;
      len <= new_len;
      apl <= new_apl;
      strb_end <= new_strb;
      mux <= addr_mux_select;
      // Full 8-bit mux always runs a byte-wide bus
      wide <= (addr_mux_select == pmat_pkg::MUX_FULL16) ||
              (mode16 && addr_mux_select != pmat_pkg::MUX_FULL8);
      if (data_wr)
      begin
        wdata <= data_wdata;
      end
    end
  end

  // Next cycle position
  always_comb
  begin
    next_active = active;
    next_cnt = cnt;
    if (start)
    begin
      next_active = 1'b1;
      next_cnt = 5'h00;
    end
    else if (finish)
    begin
      next_active = 1'b0;
      next_cnt = 5'h00;
    end
    else if (active)
    begin
      next_cnt = 5'(cnt + 5'h01);
    end
  end

  // Phase decode of the next position, with start-time values when starting
  logic [4:0] d_apl;
  logic [4:0] d_strb;
  logic [4:0] d_len;
  logic d_write;
  logic [1:0] d_mux;
  always_comb
  begin
    d_apl = start ? new_apl : apl;
    d_strb = start ? new_strb : strb_end;
    d_len = start ? new_len : len;
    d_write = start ? data_wr : is_write;
    d_mux = start ? addr_mux_select : mux;
    if (!next_active)
      next_phase = pmat_pkg::PH_IDLE;
    else if (next_cnt < d_apl)
      next_phase = pmat_pkg::PH_ADDR;
    else if (next_cnt < 5'(d_apl + pmat_pkg::SETUP_CYC))
      next_phase = pmat_pkg::PH_SETUP;
    else if (next_cnt < d_strb)
      next_phase = pmat_pkg::PH_STROBE;
    else
      next_phase = pmat_pkg::PH_HOLD;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      cnt <= 5'h00;
      phase <= pmat_pkg::PH_IDLE;
    end
    else
    begin
      active <= next_active;
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end

  // Busy set by the starting access, dropped in the last cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= next_active && (next_cnt != 5'(d_len - 5'h01));
  end

  // Address register; writes while busy are dropped
  logic [ADDR_W-1:0] inc_mask;
  logic [ADDR_W-1:0] inc_addr;
  always_comb
  begin
    inc_mask = '1;
    inc_mask[pmat_pkg::CS_UPPER_BIT] = !cs_up_en;
    inc_mask[pmat_pkg::CS_LOWER_BIT] = !cs_lo_en;
    // Select bits kept out of the count so a carry cannot move the device
    inc_addr = ((bus_address_reg & inc_mask) + ADDR_W'(1)) & inc_mask;
    inc_addr = inc_addr | (bus_address_reg & ~inc_mask);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bus_address_reg <= pmat_pkg::ADDR_RESET;
    else if (addr_wr && !busy)
      bus_address_reg <= addr_wdata;
    else if (finish && auto_inc_enable)
      bus_address_reg <= inc_addr;
  end

  // Read data latched at the end of the strobe; software sees it next read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bus_data_reg <= pmat_pkg::DATA_RESET;
    else if (finish && !is_write)
      bus_data_reg <= wide ? ext_data_in : {8'h00, ext_data_in[7:0]};
  end

  // Address as sent on the data bus, select bits zeroed
  logic [ADDR_W-1:0] mux_addr;
  always_comb
  begin
    mux_addr = bus_address_reg;
    mux_addr[pmat_pkg::CS_UPPER_BIT] = bus_address_reg[pmat_pkg::CS_UPPER_BIT] & !cs_up_en;
    mux_addr[pmat_pkg::CS_LOWER_BIT] = bus_address_reg[pmat_pkg::CS_LOWER_BIT] & !cs_lo_en;
  end

  // Next pin values
  logic [DATA_W-1:0] next_data;
  logic next_oe_low;
  logic next_oe_high;
  logic next_al;
  logic next_ah;
  logic d_wide;
  always_comb
  begin
    d_wide = start ? ((addr_mux_select == pmat_pkg::MUX_FULL16) ||
                      (mode16 && addr_mux_select != pmat_pkg::MUX_FULL8)) : wide;
    next_data = '0;
    next_oe_low = 1'b0;
    next_oe_high = 1'b0;
    next_al = 1'b0;
    next_ah = 1'b0;
    case (next_phase)
      pmat_pkg::PH_ADDR:
      begin
        next_oe_low = 1'b1;
        if (d_mux == pmat_pkg::MUX_FULL16)
        begin
          next_data = DATA_W'(mux_addr);
          next_oe_high = 1'b1;
          next_al = (next_cnt == pmat_pkg::LATCH_LOW_CYC);
        end
        else if (d_mux == pmat_pkg::MUX_FULL8 && next_cnt >= pmat_pkg::HIGH_BYTE_START)
        begin
          next_data = {8'h00, mux_addr[15:8]};
          next_ah = (next_cnt == pmat_pkg::LATCH_HIGH_CYC);
        end
        else
        begin
          next_data = {8'h00, mux_addr[7:0]};
          next_al = (next_cnt == pmat_pkg::LATCH_LOW_CYC);
        end
      end
      pmat_pkg::PH_SETUP, pmat_pkg::PH_STROBE, pmat_pkg::PH_HOLD:
      begin
        if (d_write)
        begin
          next_data = start ? data_wdata : wdata;
          next_oe_low = 1'b1;
          next_oe_high = d_wide;
          if (!d_wide)
          begin
            next_data[15:8] = 8'h00;
          end
        end
      end
      default: next_data = '0;
    endcase
  end

  // Pin registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_data_lines <= '0;
      ext_data_oe_low <= 1'b0;
      ext_data_oe_high <= 1'b0;
      addr_latch_low <= 1'b0;
      addr_latch_high <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
    end
    else
    begin
      ext_data_lines <= next_data;
      ext_data_oe_low <= next_oe_low;
      ext_data_oe_high <= next_oe_high;
      addr_latch_low <= next_al;
      addr_latch_high <= next_ah;
      read_strobe <= (next_phase == pmat_pkg::PH_STROBE) && !d_write;
      write_strobe <= (next_phase == pmat_pkg::PH_STROBE) && d_write;
    end
  end

  // Address lines and shared select pins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_address_lines <= 14'h0000;
      upper_chip_select <= 1'b0;
      lower_chip_select <= 1'b0;
      cfg_unsupported <= 1'b0;
    end
    else
    begin
      // Low lines always carry the address, select or not
      ext_address_lines <= bus_address_reg[13:0];
      // Both selects can fire together if both bits are set
      upper_chip_select <= cs_up_en ? (next_active && bus_address_reg[pmat_pkg::CS_UPPER_BIT])
        : bus_address_reg[pmat_pkg::CS_UPPER_BIT];
      lower_chip_select <= cs_lo_en ? (next_active && bus_address_reg[pmat_pkg::CS_LOWER_BIT])
        : bus_address_reg[pmat_pkg::CS_LOWER_BIT];
      cfg_unsupported <= cs_lower_enable && !cs_upper_enable;
    end
  end

endmodule

// ===== include/pmat_pkg.sv
// Shared constants and types for the parallel master address and timing block
package pmat_pkg;

  // Address/data multiplex settings
  localparam logic [1:0] MUX_DEMUX = 2'h0;
  localparam logic [1:0] MUX_PARTIAL = 2'h1;
  localparam logic [1:0] MUX_FULL8 = 2'h2;
  localparam logic [1:0] MUX_FULL16 = 2'h3;

  // Address phase lengths in ref_clk cycles
  localparam logic [4:0] ADDR_CYC_DEMUX = 5'h00;
  localparam logic [4:0] ADDR_CYC_PARTIAL = 5'h03;
  localparam logic [4:0] ADDR_CYC_FULL8 = 5'h06;
  localparam logic [4:0] ADDR_CYC_FULL16 = 5'h03;

  // Address latch pulse positions inside the address phase
  localparam logic [4:0] LATCH_LOW_CYC = 5'h01;
  localparam logic [4:0] LATCH_HIGH_CYC = 5'h04;
  localparam logic [4:0] HIGH_BYTE_START = 5'h03;

  // Setup and strobe lengths without wait states
  localparam logic [4:0] SETUP_CYC = 5'h01;
  localparam logic [4:0] STROBE_CYC = 5'h01;
  localparam logic [4:0] HOLD_CYC = 5'h01;

  // Strobe extension with wait states enabled
  localparam logic [4:0] WAIT_EXT_DEMUX = 5'h04;
  localparam logic [4:0] WAIT_EXT_PARTIAL = 5'h05;
  localparam logic [4:0] WAIT_EXT_FULL8 = 5'h06;
  localparam logic [4:0] WAIT_EXT_FULL16 = 5'h05;

  // Address bit positions shared with chip selects
  localparam int CS_UPPER_BIT = 15;
  localparam int CS_LOWER_BIT = 14;

  // Reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Bus cycle phases
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_ADDR = 5'h02,
    PH_SETUP = 5'h04,
    PH_STROBE = 5'h08,
    PH_HOLD = 5'h10
  } pmat_phase_t;

endpackage

// ===== tb/pmat_chk.sv
// Port checker for the parallel master block
module pmat_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] addr_mux_select,
  input wire logic mode16,
  input wire logic wait_enable,
  input wire logic cs_upper_enable,
  input wire logic cs_lower_enable,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [15:0] bus_address_reg,
  input wire logic busy,
  input wire logic [13:0] ext_address_lines,
  input wire logic upper_chip_select,
  input wire logic lower_chip_select,
  input wire logic [15:0] ext_data_lines,
  input wire logic ext_data_oe_low,
  input wire logic ext_data_oe_high,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic addr_latch_low,
  input wire logic addr_latch_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Read lengths indexed by {wait, mux}; writes add one
  localparam logic [39:0] RD_LEN = {5'h0a, 5'h0e, 5'h0a, 5'h06, 5'h05, 5'h08, 5'h05, 5'h02};
  logic start;
  logic narrow;
  logic [4:0] exp_len;
  logic [4:0] cnt;
  assign start = (data_wr | data_rd) & ~busy;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      exp_len <= 5'h00;
      narrow <= 1'b0;
    end
    else if (start)
    begin
      exp_len <= RD_LEN[{wait_enable, addr_mux_select} * 5 +: 5] + {4'h0, data_wr};
      narrow <= addr_mux_select == pmat_pkg::MUX_FULL8 || (!mode16 && !addr_mux_select[1]);
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt <= 5'h00;
    else
      cnt <= busy ? cnt + 5'h01 : 5'h00;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_busy_sets: assert property (start |=> busy)
    else $error("busy not raised");
  a_busy_length: assert property ($fell(busy) |-> cnt == exp_len - 5'h01)
    else $error("busy span wrong");
  a_select_pins: assert property ((read_strobe | write_strobe) |->
    {upper_chip_select, lower_chip_select} == bus_address_reg[15:14])
    else $error("select pins wrong");
  a_low_address: assert property ((read_strobe | write_strobe) && addr_mux_select == 2'h0
    |-> ext_address_lines == bus_address_reg[13:0])
    else $error("address lines wrong");
  a_write_hold: assert property ($fell(write_strobe) |->
    !busy && ext_data_oe_low && $stable(ext_data_lines))
    else $error("write hold wrong");
  a_byte_lanes: assert property (busy && narrow |-> !ext_data_oe_high)
    else $error("upper lane driven");
  a_latch_order: assert property (start && addr_mux_select == pmat_pkg::MUX_FULL8
    |-> ##2 addr_latch_low ##3 addr_latch_high)
    else $error("latch order wrong");
  a_select_forced: assert property (addr_latch_high && cs_upper_enable
    |-> !(ext_data_lines[7] | (cs_lower_enable & ext_data_lines[6])))
    else $error("select bit not zero");
  a_partial_address: assert property (addr_latch_low && addr_mux_select == 2'h1
    |-> ext_data_lines[7:0] == bus_address_reg[7:0])
    else $error("low address byte wrong");
endmodule

bind pmat_master pmat_chk u_chk (.*);

// ===== tb/pmat_ext_dev.sv
// External parallel device model on the far side of the bus
module pmat_ext_dev (
  input wire logic ref_clk,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic ext_data_oe_high,
  input wire logic [15:0] ext_data_lines,
  output logic [15:0] ext_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] store = 16'h0000;
  logic [15:0] noise = 16'h0000;
  always @(posedge ref_clk)
  begin
    if (write_strobe)
      store[7:0] <= ext_data_lines[7:0];
    // Byte writes leave a stale upper byte, so an unmasked narrow read shows it
    if (write_strobe && ext_data_oe_high)
      store[15:8] <= ext_data_lines[15:8];
    noise <= noise + 16'h1357;
  end
  // Released bus shows junk so a stale value never passes
  assign ext_data_in = read_strobe ? store : noise;
endmodule

// ===== tb/tb.sv
// Testbench for the parallel master block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr_mux_select = 2'h0;
  logic mode16 = 1'b1, wait_enable = 1'b0, auto_inc_enable = 1'b0;
  logic cs_upper_enable = 1'b0, cs_lower_enable = 1'b0;
  logic addr_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic [15:0] addr_wdata = 16'h0000, data_wdata = 16'h0000;
  logic [15:0] ext_data_in, bus_data_reg, bus_address_reg, ext_data_lines;
  logic busy, cfg_unsupported, upper_chip_select, lower_chip_select;
  logic ext_data_oe_low, ext_data_oe_high, read_strobe, write_strobe;
  logic addr_latch_low, addr_latch_high;
  logic [13:0] ext_address_lines;
  logic [15:0] d;
  int mismatches = 0;
  int samples_checked = 0;

  pmat_master u_dut (.*);
  pmat_ext_dev u_ext (.*);

  initial forever #12.5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [4:0] cyc_len(input logic [2:0] k, input logic wr);
    logic [39:0] t;
    t = {5'h0a, 5'h0e, 5'h0a, 5'h06, 5'h05, 5'h08, 5'h05, 5'h02};
    return t[k * 5 +: 5] + {4'h0, wr};
  endfunction

  // All tasks start and end on a falling edge
  task automatic set_addr(input logic [15:0] a);
    addr_wr = 1'b1;
    addr_wdata = a;
    @(negedge ref_clk);
    addr_wr = 1'b0;
  endtask

  // Poke tries a read start while busy; it must be ignored
  task automatic op(input logic wr, input logic [15:0] v, input logic poke);
    int n;
    logic [4:0] len;
    n = 0;
    len = cyc_len({wait_enable, addr_mux_select}, wr);
    data_wr = wr;
    data_rd = ~wr;
    data_wdata = v;
    @(negedge ref_clk);
    data_wr = 1'b0;
    data_rd = poke;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      @(negedge ref_clk);
      data_rd = 1'b0;
    end
    chk("busy span", {11'h000, len - 5'h01}, n[15:0]);
  endtask

  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    cs_upper_enable = 1'b1;
    cs_lower_enable = 1'b1;
    set_addr(16'hc0a5);
    for (int k = 0; k < 8; k++)
    begin
      addr_mux_select = k[1:0];
      wait_enable = k[2];
      d = 16'h5a30 ^ {13'h0000, k[2:0]};
      op(1'b1, d, 1'b0);
      op(1'b0, 16'h0000, 1'b0);
      @(negedge ref_clk);
      chk("read data", k[1:0] == 2'h2 ? {8'h00, d[7:0]} : d, bus_data_reg);
    end
    $display("test cycle lengths done");
    mode16 = 1'b0;
    addr_mux_select = 2'h0;
    wait_enable = 1'b0;
    auto_inc_enable = 1'b1;
    set_addr(16'h7fff);
    op(1'b1, 16'ha5c3, 1'b1);
    @(negedge ref_clk);
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("address", 16'h4000, bus_address_reg);
    op(1'b0, 16'h0000, 1'b0);
    @(negedge ref_clk);
    chk("read data", 16'h00c3, bus_data_reg);
    $display("test refusal and increment done");
    auto_inc_enable = 1'b0;
    cs_upper_enable = 1'b0;
    cs_lower_enable = 1'b0;
    set_addr(16'hc123);
    // No select pins: the software select on a spare pin spans this access
    op(1'b0, 16'h0000, 1'b0);
    cs_lower_enable = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("unsupported", 16'h0001, {15'h0000, cfg_unsupported});
    $display("test select setups done");
    conclude();
  end

  // Whole run takes well under 1000 cycles
  initial
  begin
    #50000;
    mismatches++;
    conclude();
  end
endmodule
